/* File: src/rdp_consts.vh */
// constants for the radio data port: format codes, divider tables, timing
// assumes inclusion by bare name from the port design files
`ifndef RDP_CONSTS_VH
`define RDP_CONSTS_VH

// format select codes
`define RDP_FMT_SYNC_NRZ   2'h0
`define RDP_FMT_SYNC_MAN   2'h1
`define RDP_FMT_ASYNC      2'h2
`define RDP_FMT_STATIC_BIT 0

// fixed crystal prescale ahead of the reference divider
`define RDP_XTAL_PRESCALE  4'h8

// first divider factors, stored as half-units (factor times two)
`define RDP_DIV1_C0 7'h05
`define RDP_DIV1_C1 7'h06
`define RDP_DIV1_C2 7'h08
`define RDP_DIV1_C3 7'h0F
`define RDP_DIV1_C4 7'h19
`define RDP_DIV1_C5 7'h50
`define RDP_DIV1_C6 7'h60
`define RDP_DIV1_C7 7'h7F

// clock figures
`define RDP_CLK_PERIOD_NS  10
`define RDP_DEMOD_MAX_KBD  1536

// receive sync: decoded symbol pairs of phase lock at which the lock count saturates
`define RDP_LOCK_SYMBOLS   4'h4

`endif

/* File: src/rdp_baud_gen.v */
// baud tick generator: crystal clock through prescale, reference and two dividers
// assumes CLK is the crystal clock and divider codes are held stable by the user
`timescale 1ns/1ps
`default_nettype none
`include "rdp_consts.vh"

module rdp_baud_gen (
    input  wire       CLK,
    input  wire       RESETN,
    input  wire [2:0] REF_DIV,
    input  wire [2:0] DIV1_CODE,
    input  wire [1:0] DIV2_CODE,
    output reg        HALF_TICK,
    output reg        SYM_TICK
);

    // half-unit first-divider factor, decoded from the 3-bit code
    function [6:0] div1_half;
        input [2:0] code;
        begin
            case (code)
                3'h0:    div1_half = `RDP_DIV1_C0;
                3'h1:    div1_half = `RDP_DIV1_C1;
                3'h2:    div1_half = `RDP_DIV1_C2;
                3'h3:    div1_half = `RDP_DIV1_C3;
                3'h4:    div1_half = `RDP_DIV1_C4;
                3'h5:    div1_half = `RDP_DIV1_C5;
                3'h6:    div1_half = `RDP_DIV1_C6;
                default: div1_half = 7'h00;
            endcase
        end
    endfunction

    // code 7 wants 128 half-units, past the 7-bit table width
    wire [7:0] half_units = (DIV1_CODE == 3'h7) ? 8'h80 : {1'b0, div1_half(DIV1_CODE)};
    // second divider 1,2,4,8 as a shift
    wire [3:0] div2_fac   = 4'h1 << DIV2_CODE;

    // stage a: crystal / (8 * (ref+1) / 2) gives a half-unit tick (4*(ref+1) clocks)
    reg [4:0] pre_cnt_reg;
    wire [4:0] pre_top = {REF_DIV, 2'h0} + 5'h3;
    wire       pre_tick = (pre_cnt_reg == pre_top);

    // stage b: count half-units; fractional factors average exactly
    reg [7:0] d1_cnt_reg;
    reg [3:0] d2_cnt_reg;
    reg       d1_tick_reg;

    // prescale and reference divider
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pre_cnt_reg <= 5'h00;
        end else if (pre_tick) begin
            pre_cnt_reg <= 5'h00;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 5'h01;
        end
    end

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            d1_cnt_reg  <= 8'h00;
            d1_tick_reg <= 1'b0;
        end else begin
            d1_tick_reg <= 1'b0;
            if (pre_tick) begin
                if (d1_cnt_reg + 8'h01 >= half_units) begin
                    d1_cnt_reg  <= 8'h00;
                    d1_tick_reg <= 1'b1;
                end else begin
                    d1_cnt_reg <= d1_cnt_reg + 8'h01;
                end
            end
        end
    end

    // second divider, symbol tick and mid-symbol tick
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            d2_cnt_reg <= 4'h0;
            SYM_TICK   <= 1'b0;
            HALF_TICK  <= 1'b0;
        end else begin
            SYM_TICK  <= 1'b0;
            HALF_TICK <= 1'b0;
            if (d1_tick_reg) begin
                if (d2_cnt_reg + 4'h1 >= div2_fac) begin
                    d2_cnt_reg <= 4'h0;
                    SYM_TICK   <= 1'b1;
                end else begin
                    d2_cnt_reg <= d2_cnt_reg + 4'h1;
                end
            end
            // mid-symbol point: halfway through the half-unit count for factor 1
            if (pre_tick && d2_cnt_reg == 4'h0 && d1_cnt_reg == {1'b0, half_units[7:1]}) begin
                HALF_TICK <= 1'b1;
            end
        end
    end

endmodule // rdp_baud_gen
`default_nettype wire

/* File: src/rdp_data_port.v */
// data-path port of a narrowband radio: sync NRZ, sync Manchester, transparent async
// assumes pins synchronous to CLK; modem sits on TX_SYMBOL / RX_DEMOD
`timescale 1ns/1ps
`default_nettype none
`include "rdp_consts.vh"

// Contract
// - device drives bit clock, samples on rise
// - device Manchester-encodes; bit rate half baud
// - receive recovers timing, decodes, drives clock
// - bit clock runs continuously in sync
// - split 0: shared pin in/out by direction
// - split 1 sync: lock pin carries data
// - async transmit passes level unencoded
// - async receive outputs raw demod level
// - async split 0: clock pin static format bit0
// - async split 1: clock pin is rx data
// - zero low-high, one high-low
// - baud = xtal/8/(ref+1)/div1/div2
// - second divider 1, 2, 4, 8
// - first divider table of eight factors
// - two-bit format select field
// - sync NRZ transmit unencoded on rise
module rdp_data_port (
    input  wire       CLK,
    input  wire       RESETN,
    input  wire [1:0] DATA_FORMAT,
    input  wire       SPLIT_DATA_PINS,
    input  wire       TX_MODE,
    input  wire [2:0] REF_DIV,
    input  wire [2:0] BAUD_DIV_FIRST,
    input  wire [1:0] BAUD_DIV_SECOND,
    input  wire       LOCK_STATUS_IN,
    input  wire       RX_DEMOD,
    input  wire       SHARED_DATA_PIN_I,
    output reg        SHARED_DATA_PIN_O,
    output reg        SHARED_DATA_PIN_OE,
    output reg        BIT_CLOCK_PIN,
    output reg        LOCK_PIN,
    output reg        TX_SYMBOL
);

    // format states, one-hot
    localparam [2:0] ST_NRZ  = 3'h1;
    localparam [2:0] ST_MAN  = 3'h2;
    localparam [2:0] ST_ASYN = 3'h4;

    wire half_tick;                  // mid-symbol strobe
    wire sym_tick;                   // symbol boundary strobe

    rdp_baud_gen u_baud (
        .CLK       (CLK),
        .RESETN    (RESETN),
        .REF_DIV   (REF_DIV),
        .DIV1_CODE (BAUD_DIV_FIRST),
        .DIV2_CODE (BAUD_DIV_SECOND),
        .HALF_TICK (half_tick),
        .SYM_TICK  (sym_tick)
    );

    // format decode, shared by tx and pin muxing
    function [2:0] fmt_state;
        input [1:0] f;
        begin
            case (f)
                `RDP_FMT_SYNC_NRZ: fmt_state = ST_NRZ;
                `RDP_FMT_SYNC_MAN: fmt_state = ST_MAN;
                default:           fmt_state = ST_ASYN;
            endcase
        end
    endfunction

    reg  [2:0] state_reg;            // registered format state
    wire       is_sync  = (state_reg != ST_ASYN);
    wire       is_man   = (state_reg == ST_MAN);
    wire       static_lvl = DATA_FORMAT[`RDP_FMT_STATIC_BIT];

    reg        sym_phase_reg;        // manchester half within a bit
    reg        bclk_reg;             // internal bit clock level
    reg        tx_bit_reg;           // sampled nrz bit
    reg        rx_prev_reg;          // demod level at previous mid point
    reg        rx_first_reg;         // first half of received symbol pair
    reg        rx_pair_reg;          // pair phase in receive
    reg        rx_bit_reg;           // decoded receive data
    reg  [3:0] lock_cnt_reg;         // symbol pairs decoded since phase slip
    reg        rx_raw_reg;           // raw demod level registered

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= ST_NRZ;
        end else begin
            state_reg <= fmt_state(DATA_FORMAT);
        end
    end

    // bit clock: in NRZ one period per symbol, in Manchester one per symbol pair
    // free running clock
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            bclk_reg      <= 1'b0;
            sym_phase_reg <= 1'b0;
        end else if (sym_tick) begin
            sym_phase_reg <= ~sym_phase_reg;
            if (is_man) begin
                // bit clock at half the baud rate
                bclk_reg <= ~sym_phase_reg;
            end else begin
                bclk_reg <= 1'b1;
            end
        end else if (half_tick && !is_man) begin
            bclk_reg <= 1'b0;
        end
    end

    // rising edge of the bit clock, decoded in the same cycle that drives bclk_reg high
    wire bclk_rise = sym_tick && (is_man ? !sym_phase_reg : 1'b1);

    // sample host nrz data on the rising bit clock
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_bit_reg <= 1'b0;
        end else if (bclk_rise) begin
            tx_bit_reg <= SHARED_DATA_PIN_I;
        end
    end

    // transmit symbol to modulator
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            TX_SYMBOL <= 1'b0;
        end else begin
            case (state_reg)
                ST_NRZ: TX_SYMBOL <= tx_bit_reg;
                // zero: low then high; one: high then low
                // phase is already set in the first half, so the bit goes out first
                ST_MAN: TX_SYMBOL <= sym_phase_reg ? tx_bit_reg : ~tx_bit_reg;
                ST_ASYN: TX_SYMBOL <= SHARED_DATA_PIN_I;
                default: TX_SYMBOL <= 1'b0;
            endcase
        end
    end

    // receive: sample demod mid-symbol, decode manchester pairs
    // a pair with no transition is a phase slip, so the pair phase is shifted
    // timing recovery and decode
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_prev_reg  <= 1'b0;
            rx_first_reg <= 1'b0;
            rx_pair_reg  <= 1'b0;
            rx_bit_reg   <= 1'b0;
            lock_cnt_reg <= 4'h0;
        end else if (half_tick) begin
            rx_prev_reg <= RX_DEMOD;
            if (!is_man) begin
                rx_bit_reg <= RX_DEMOD;
            end else if (!rx_pair_reg) begin
                rx_first_reg <= RX_DEMOD;
                rx_pair_reg  <= 1'b1;
            end else if (rx_first_reg != RX_DEMOD) begin
                rx_bit_reg  <= rx_first_reg;
                rx_pair_reg <= 1'b0;
                if (lock_cnt_reg != `RDP_LOCK_SYMBOLS) begin
                    lock_cnt_reg <= lock_cnt_reg + 4'h1;
                end
            end else begin
                // slip half a bit: this sample starts the next pair
                rx_first_reg <= RX_DEMOD;
                lock_cnt_reg <= 4'h0;
            end
        end
    end

    // raw level for transparent receive
    // no synchronisation applied
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_raw_reg <= 1'b0;
        end else begin
            rx_raw_reg <= RX_DEMOD;
        end
    end

    wire rx_data = is_sync ? rx_bit_reg : rx_raw_reg;

    // pin routing by format, direction and split setting
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            SHARED_DATA_PIN_O  <= 1'b0;
            SHARED_DATA_PIN_OE <= 1'b0;
            BIT_CLOCK_PIN      <= 1'b0;
            LOCK_PIN           <= 1'b0;
        end else begin
            // shared pin drives only when receiving, unsplit
            SHARED_DATA_PIN_OE <= !TX_MODE && !SPLIT_DATA_PINS;
            SHARED_DATA_PIN_O  <= rx_data;
            LOCK_PIN           <= LOCK_STATUS_IN;
            if (is_sync) begin
                // clock always toggles in sync formats
                BIT_CLOCK_PIN <= bclk_reg;
                if (SPLIT_DATA_PINS && !TX_MODE) begin
                    // lock pin overridden by rx data
                    LOCK_PIN <= rx_data;
                end
            end else if (SPLIT_DATA_PINS && !TX_MODE) begin
                // clock pin carries raw rx data
                BIT_CLOCK_PIN <= rx_data;
            end else begin
                // static level from format bit 0
                BIT_CLOCK_PIN <= static_lvl;
            end
        end
    end

endmodule // rdp_data_port
`default_nettype wire

/* File: verification/rdp_port_monitor.sv */
// checker for the radio data port, bound to its top module
// assumes one crystal clock domain and the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module rdp_port_monitor (
    input wire logic       CLK,
    input wire logic       RESETN,
    input wire logic [1:0] DATA_FORMAT,
    input wire logic       SPLIT_DATA_PINS,
    input wire logic       TX_MODE,
    input wire logic       RX_DEMOD,
    input wire logic       SHARED_DATA_PIN_I,
    input wire logic       SHARED_DATA_PIN_O,
    input wire logic       SHARED_DATA_PIN_OE,
    input wire logic       BIT_CLOCK_PIN,
    input wire logic       LOCK_PIN,
    input wire logic       TX_SYMBOL
);
    wire         asy = DATA_FORMAT[1];     // transparent format
    wire         spl = SPLIT_DATA_PINS;    // split data pins
    logic [10:0] idle_reg;                 // cycles since the bit clock moved
    logic        bclk_reg;                 // bit clock one cycle back
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // counts only in sync formats; wide enough for the slowest divider used
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            idle_reg <= 11'h000;
            bclk_reg <= 1'b0;
        end else begin
            bclk_reg <= BIT_CLOCK_PIN;
            idle_reg <= (asy || BIT_CLOCK_PIN != bclk_reg) ? 11'h000 : idle_reg + 11'h001;
        end
    end
    chk_clk_keeps_running:
        assert property (idle_reg < 11'h5DC) else $error("bit clock stalled");
    chk_async_clk_static:
        assert property ((asy && !spl && $stable(DATA_FORMAT))[*3] |->
            BIT_CLOCK_PIN == DATA_FORMAT[0]) else $error("clock pin not static");
    chk_async_tx_static:
        assert property ((asy && spl && TX_MODE && $stable(DATA_FORMAT))[*3] |->
            BIT_CLOCK_PIN == DATA_FORMAT[0]) else $error("clock pin not static in tx");
    chk_async_rx_clkpin:
        assert property ((asy && spl && !TX_MODE && $stable(RX_DEMOD))[*4] |->
            BIT_CLOCK_PIN == RX_DEMOD) else $error("clock pin not rx data");
    chk_async_rx_raw:
        assert property ((asy && !spl && !TX_MODE && $stable(RX_DEMOD))[*4] |->
            SHARED_DATA_PIN_O == RX_DEMOD) else $error("data pin not raw level");
    chk_async_tx_pass:
        assert property ((asy && TX_MODE && $stable(SHARED_DATA_PIN_I))[*4] |->
            TX_SYMBOL == SHARED_DATA_PIN_I) else $error("tx level not passed");
    chk_pin_direction:
        assert property ((!spl && $stable(TX_MODE))[*3] |->
            SHARED_DATA_PIN_OE == !TX_MODE) else $error("data pin direction wrong");
    chk_rx_hold_rise:
        assert property ((!asy && !TX_MODE && !spl)[*3] ##0 $rose(BIT_CLOCK_PIN) |->
            $stable(SHARED_DATA_PIN_O)) else $error("rx data moved at clock rise");
    chk_lock_hold_rise:
        assert property ((!asy && !TX_MODE && spl)[*3] ##0 $rose(BIT_CLOCK_PIN) |->
            $stable(LOCK_PIN)) else $error("lock pin data moved at rise");
endmodule // rdp_port_monitor
bind rdp_data_port rdp_port_monitor u_mon (.CLK(CLK), .RESETN(RESETN),
    .DATA_FORMAT(DATA_FORMAT), .SPLIT_DATA_PINS(SPLIT_DATA_PINS), .TX_MODE(TX_MODE),
    .RX_DEMOD(RX_DEMOD), .SHARED_DATA_PIN_I(SHARED_DATA_PIN_I),
    .SHARED_DATA_PIN_O(SHARED_DATA_PIN_O), .SHARED_DATA_PIN_OE(SHARED_DATA_PIN_OE),
    .BIT_CLOCK_PIN(BIT_CLOCK_PIN), .LOCK_PIN(LOCK_PIN), .TX_SYMBOL(TX_SYMBOL));
`default_nettype wire

/* File: verification/rdp_host_model.sv */
// host model: feeds tx bits on the bit clock, captures rx bits
// assumes the device bit clock and the crystal clock of the bench
`timescale 1ns/1ps
`default_nettype none
module rdp_host_model (
    input  wire logic       clk,
    input  wire logic       bclk,
    input  wire logic       rx_bit,
    input  wire logic       sym,
    input  wire logic       man,
    output var  logic       tx_bit,
    output var  logic [7:0] rx_sh,
    output var  int         ok_n,
    output var  int         bad_n
);
    logic [7:0] pat_reg = 8'h0B;   // rotating tx pattern
    logic       sent = 1'b0;       // bit the device took for this bit
    initial tx_bit = 1'b0;
    initial rx_sh = 8'h00;
    initial ok_n = 0;
    initial bad_n = 0;
    always @(posedge bclk) begin
        rx_sh <= {rx_sh[6:0], rx_bit};
        sent <= tx_bit;
    end
    // present on fall; held across the next rise
    always @(negedge bclk) begin
        @(negedge clk);
        tx_bit <= pat_reg[7];
        pat_reg <= {pat_reg[6:0], pat_reg[7]};
    end
    always @(posedge bclk) begin
        repeat (5) @(negedge clk);
        if (sym === sent) ok_n++;
        else bad_n++;
    end
    always @(negedge bclk) begin
        repeat (5) @(negedge clk);
        if (man && sym === ~sent) ok_n++;
        else if (man) bad_n++;
    end
endmodule // rdp_host_model
`default_nettype wire

/* File: verification/rdp_data_port_tb.sv */
// self-checking bench for the radio data port
// assumes the host model and the bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module rdp_data_port_tb;
    logic       CLK = 1'b0;     // crystal clock
    logic       RESETN = 1'b0;  // reset, active low
    logic [1:0] fmt = 2'h0;     // format select
    logic       split = 1'b0;   // split data pins
    logic       txm = 1'b0;     // transmit mode
    logic [2:0] rdiv = 3'h0;    // reference divider
    logic [2:0] d1 = 3'h0;      // first divider code
    logic [1:0] d2 = 2'h0;      // second divider code
    logic       demod = 1'b0;   // demodulator level
    logic       a_tx = 1'b0;    // transparent tx level
    logic       lock_in = 1'b1; // normal lock status level
    logic       h_tx, dio_o, dio_oe, bclk, lock_o, sym;
    logic [7:0] rx_sh;          // bits the host captured
    int         ok_n, bad_n, n_errors = 0, cmp_count = 0, cyc = 0;
    int         half_tab [8] = '{5, 6, 8, 15, 25, 80, 96, 128}; // factor times two
    rdp_data_port u_dut (.CLK(CLK), .RESETN(RESETN), .DATA_FORMAT(fmt),
        .SPLIT_DATA_PINS(split), .TX_MODE(txm), .REF_DIV(rdiv), .BAUD_DIV_FIRST(d1),
        .BAUD_DIV_SECOND(d2), .LOCK_STATUS_IN(lock_in), .RX_DEMOD(demod),
        .SHARED_DATA_PIN_I(fmt[1] ? a_tx : h_tx), .SHARED_DATA_PIN_O(dio_o),
        .SHARED_DATA_PIN_OE(dio_oe), .BIT_CLOCK_PIN(bclk), .LOCK_PIN(lock_o),
        .TX_SYMBOL(sym));
    rdp_host_model u_host (.clk(CLK), .bclk(bclk), .rx_bit(split ? lock_o : dio_o),
        .sym(sym), .man(fmt == 2'h1), .tx_bit(h_tx), .rx_sh(rx_sh), .ok_n(ok_n),
        .bad_n(bad_n));
    initial forever #5 CLK = ~CLK;
    // hang guard, about half again above the expected run
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            print_verdict;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            n_errors++;
            $display("[FAIL] %0t got %0h want %0h", $time, got, want);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // symbol period measured over four NRZ bit clock rises
    task automatic t_baud(input logic [2:0] r, input logic [2:0] c1, input logic [1:0] c2);
        realtime t0;
        @(negedge CLK);
        fmt = 2'h0;
        txm = 1'b1;
        rdiv = r;
        d1 = c1;
        d2 = c2;
        repeat (2) @(posedge bclk);
        t0 = $realtime;
        repeat (4) @(posedge bclk);
        chk(int'(($realtime - t0) / 40.0), 4 * (r + 1) * half_tab[c1] * (1 << c2));
    endtask
    // sync transmit through the host, then a periodic receive stream
    task automatic t_sync(input logic [1:0] f, input logic s);
        int         o0;
        int         b0;
        logic       hit;
        logic [15:0] pp;
        pp = 16'h0B0B;
        hit = 1'b0;
        @(negedge CLK);
        fmt = f;
        split = s;
        txm = 1'b1;
        rdiv = 3'h0;
        d1 = 3'h0;
        d2 = 2'h0;
        repeat (3) @(posedge bclk);
        o0 = ok_n;
        b0 = bad_n;
        repeat (32) @(posedge bclk);
        chk(bad_n - b0, 0);
        chk(ok_n - o0 >= 32, 1);
        chk(dio_oe, 0);
        chk(lock_o, lock_in);
        @(negedge CLK);
        txm = 1'b0;
        for (int i = 0; i < 48; i++) begin
            for (int h = 0; h <= int'(f[0]); h++) begin
                demod = pp[7 - i % 8] ^ h[0];
                repeat (20) @(negedge CLK);
            end
        end
        for (int k = 0; k < 8; k++) if (rx_sh === pp[k +: 8]) hit = 1'b1;
        chk(hit, 1);
        if (!s) chk(dio_oe, 1);
    endtask
    // transparent mode, every level of format bit 0, split and direction
    task automatic t_async(input logic [1:0] f, input logic s, input logic t);
        @(negedge CLK);
        fmt = f;
        split = s;
        txm = t;
        for (int i = 0; i < 4; i++) begin
            a_tx = i[0];
            demod = ~i[0];
            // host holds each level longer than one 153.6 kBaud bit
            repeat (660) @(negedge CLK);
            if (t) chk(sym, a_tx);
            if (!s && !t) chk(dio_o, demod);
            if (s && !t) chk(bclk, demod);
            if (t || !s) chk(bclk, f[0]);
        end
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        @(negedge CLK);
        RESETN = 1'b1;
        for (int c = 0; c < 8; c++) t_baud(3'h0, c[2:0], 2'h0);
        for (int c = 1; c < 4; c++) t_baud(3'h1, 3'h3, c[1:0]);
        t_baud(3'h7, 3'h0, 2'h1);
        for (int c = 0; c < 4; c++) t_sync({1'b0, c[1]}, c[0]);
        for (int c = 0; c < 8; c++) t_async({1'b1, c[2]}, c[1], c[0]);
        print_verdict;
    end
endmodule // rdp_data_port_tb
`default_nettype wire
